// File: hdl/pao_top.sv
/*
  Digital side of a 12-stage pipelined converter: stage-code alignment,
  error correction, a 32-word buffer, the output latch with tri-state enable,
  shutdown, and track-and-hold switch sequencing.
  Assumes conversion clock, comparator codes and control pins are synchronous
  to clk, and that the conversion clock half period is at least 2 clk cycles.
*/
// What this block does
// - Enable input high puts all twelve output lines in high impedance.
// - Enable input low drives the sample word onto the output lines.
// - Shutdown input high stops conversion.
// - Output bit 0 is least significant, bit 11 most significant.
// - A sample's result appears seven conversion cycles after it is taken.
// - Twelve stages; a sample advances one stage each half conversion cycle.
// - Each stage's two comparators give a two-bit code worth one bit.
// - Redundant stage codes are combined by digital error correction.
// - Open input switches, then close feedback switches, then output switch.
// - Samples are taken on the true clock's rising edge.
// - Output is offset binary; zero input gives 1000 0000 0000.
// - Enabled outputs hold the last word during shutdown.
`timescale 1ns/10ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Word buffer: fall-through FIFO with valid and ready on both sides.
module pao_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 32
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;

  // Full and empty come from the occupancy count, so neither can lie.
  assign in_ready = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Storage has no reset; only the pointers and the count carry control state.
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // Pointers wrap naturally since the depth is a power of two.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////////
// Top level of the converter's digital side.
module pao_top (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic conv_clk_p,
  input wire logic conv_clk_n,
  input wire pao_pkg::pao_comp_t [11:0] stage_comp,
  input wire logic shutdown_request,
  input wire logic output_enable_n,
  output logic [11:0] sample_word_out,
  output logic sample_word_oe_n,
  output pao_pkg::pao_switch_t th_switch
);
  import pao_pkg::*;

  pao_slot_t slot [NUM_STAGES];
  pao_th_state_t th_state;
  logic conv_p_prev;
  logic conv_n_prev;
  logic p_rise;
  logic p_fall;
  logic n_rise;
  logic half_event;
  logic run;
  logic fifo_in_ready;
  logic fifo_in_valid;
  logic [11:0] fifo_in_data;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [11:0] fifo_out_data;
  logic [11:0] next_word;

  // A stage's thermometer code counted as 0, 1 or 2, placed at its weight.
  // An illegal code (hi without lo) is read as the top level, 2.
  function automatic logic [SUM_W-1:0] stage_weight(input pao_comp_t c, input int idx);
    logic [SUM_W-1:0] level;
    level = c.hi ? SUM_W'(2) : (c.lo ? SUM_W'(1) : SUM_W'(0));
    return level << (NUM_STAGES - 1 - idx);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Conversion clock edges; both halves advance the pipeline.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      conv_p_prev <= 1'b0;
      conv_n_prev <= 1'b1;
    end else begin
      conv_p_prev <= conv_clk_p;
      conv_n_prev <= conv_clk_n;
    end
  end

  assign p_rise = conv_clk_p && !conv_p_prev;
  assign p_fall = !conv_clk_p && conv_p_prev;
  // A single-ended clock leaves the complement at rest, so its fall counts too.
  assign n_rise = conv_clk_n && !conv_n_prev;
  // Full buffer stalls conversion rather than silently dropping words.
  // shutdown stops conversion
  assign run = !shutdown_request && fifo_in_ready;
  assign half_event = run && (p_rise || p_fall || n_rise);

  ////////////////////////////////////////////////////////////////////////////
  // twelve half-cycle stages
  // Each slot holds the partial sum of the sample now in that stage.
  // per-stage weighted code
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int j = 0; j < NUM_STAGES; j++) begin
        slot[j] <= '0;
      end
    end else if (half_event) begin
      slot[0].valid <= p_rise;
      slot[0].sum <= stage_weight(stage_comp[0], 0);
      for (int j = 1; j < NUM_STAGES; j++) begin
        slot[j].valid <= slot[j-1].valid;
        slot[j].sum <= slot[j-1].sum + stage_weight(stage_comp[j], j);
      end
    end else if (shutdown_request) begin
      // Samples in flight are abandoned so stale sums never reach the bus.
      for (int j = 0; j < NUM_STAGES; j++) begin
        slot[j].valid <= 1'b0;
      end
    end
  end

  // offset binary rounding
  // Half of (sum + 1): all-middle codes give mid scale, extremes give rails.
  assign fifo_in_data = 12'((slot[NUM_STAGES-1].sum + ROUND_ONE) >> 1);
  // finished word queued
  // Stage 11 finishes in the second half of cycle five; queue on cycle six.
  assign fifo_in_valid = run && p_rise && slot[NUM_STAGES-1].valid;

  pao_fifo #(
    .WIDTH(WORD_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .reset_n(reset_n),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in_data),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // output latch on cycle seven
  assign fifo_out_ready = !shutdown_request && p_rise;
  assign next_word = (fifo_out_valid && fifo_out_ready) ? fifo_out_data : sample_word_out;

  // bit 0 is the least significant
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sample_word_out <= RESET_WORD;
    end else begin
      sample_word_out <= next_word;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sample_word_oe_n <= 1'b1;
    end else begin
      sample_word_oe_n <= output_enable_n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // break-before-make hold sequence
  // Each step lasts one clk so the input and feedback switches never close together.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      th_state <= TH_TRACK;
    end else begin
      unique case (th_state)
        TH_TRACK: begin
          if (run && p_rise) begin
            th_state <= TH_INPUT_OPEN;
          end
        end
        TH_INPUT_OPEN: th_state <= TH_FB_CLOSED;
        TH_FB_CLOSED: th_state <= TH_HOLD;
        TH_HOLD: begin
          if (shutdown_request || p_fall || n_rise) begin
            th_state <= TH_TRACK;
          end
        end
      endcase
    end
  end

  // Switch drives are registered from the current state, one clk behind it.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      th_switch <= '0;
    end else begin
      th_switch.input_sample_switch_pos <= (th_state == TH_TRACK) && !shutdown_request;
      th_switch.input_sample_switch_neg <= (th_state == TH_TRACK) && !shutdown_request;
      th_switch.feedback_cap_switch_pos <= (th_state == TH_FB_CLOSED) || (th_state == TH_HOLD);
      th_switch.feedback_cap_switch_neg <= (th_state == TH_FB_CLOSED) || (th_state == TH_HOLD);
      th_switch.output_side_switch <= (th_state == TH_HOLD);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks kept beside the logic they guard.
  a_oe_follows_pin: assert property (@(posedge clk) disable iff (!reset_n)
    output_enable_n |=> sample_word_oe_n)
    else $error("output enable did not release the bus");
  a_oe_drives_bus: assert property (@(posedge clk) disable iff (!reset_n)
    !output_enable_n |=> !sample_word_oe_n)
    else $error("output enable did not drive the bus");
  a_shutdown_no_queue: assert property (@(posedge clk) disable iff (!reset_n)
    shutdown_request |-> !fifo_in_valid && !half_event)
    else $error("conversion continued in shutdown");
  a_shutdown_hold_word: assert property (@(posedge clk) disable iff (!reset_n)
    shutdown_request |=> $stable(sample_word_out))
    else $error("output word changed during shutdown");
  a_latch_from_fifo: assert property (@(posedge clk) disable iff (!reset_n)
    fifo_out_valid && p_rise && !shutdown_request |=> sample_word_out == $past(fifo_out_data))
    else $error("output latch missed the queued word");
  a_latch_only_rise: assert property (@(posedge clk) disable iff (!reset_n)
    !p_rise |=> $stable(sample_word_out))
    else $error("output changed off the sampling edge");
  a_stage_advance: assert property (@(posedge clk) disable iff (!reset_n)
    half_event |=> slot[NUM_STAGES-1].valid == $past(slot[NUM_STAGES-2].valid))
    else $error("pipeline slot did not advance");
  a_mid_scale: assert property (@(posedge clk) disable iff (!reset_n)
    slot[NUM_STAGES-1].sum == 13'h0FFF |-> fifo_in_data == MID_SCALE)
    else $error("mid codes did not give mid scale");
  a_switch_order: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(th_switch.output_side_switch) |-> $past(th_switch.feedback_cap_switch_pos)
      && !th_switch.input_sample_switch_pos)
    else $error("output switch closed out of order");
  a_no_overlap: assert property (@(posedge clk) disable iff (!reset_n)
    !(th_switch.input_sample_switch_pos && th_switch.feedback_cap_switch_pos))
    else $error("input and feedback switches closed together");
endmodule

`default_nettype wire

// File: hdl/pao_pkg.sv
/*
  Shared constants and carrier types for the pipelined converter's digital
  side: word layout, stage count, latency, buffer depth and timing counts.
  Assumes a 100 MHz system clock that oversamples the conversion clock.
*/
package pao_pkg;
  localparam int WORD_W = 12;
  localparam int NUM_STAGES = 12;
  localparam int SUM_W = 13;
  localparam int LATENCY_CYCLES = 7;
  localparam int FIFO_DEPTH = 32;
  // Conversion clock limits and the system clock rate.
  localparam int CONV_CLK_MIN_KHZ = 100;
  localparam int CONV_CLK_MAX_KHZ = 20000;
  localparam int SYS_CLK_KHZ = 100000;
  // Shortest conversion half period in system cycles, rounded down.
  localparam int CONV_HALF_MIN_CYCLES = SYS_CLK_KHZ / (2 * CONV_CLK_MAX_KHZ);
  // Word shown on the bus after reset, before the first conversion.
  localparam logic [11:0] RESET_WORD = 12'h000;
  // Offset binary code of a zero differential input.
  localparam logic [11:0] MID_SCALE = 12'h800;
  localparam logic [12:0] ROUND_ONE = 13'h0001;

  // One stage's two comparator outputs, thermometer coded.
  typedef struct packed {
    logic hi;
    logic lo;
  } pao_comp_t;

  // Partial corrected sum carried along with the sample it belongs to.
  typedef struct packed {
    logic valid;
    logic [SUM_W-1:0] sum;
  } pao_slot_t;

  // Track-and-hold switch controls; a one closes the switch.
  typedef struct packed {
    logic input_sample_switch_pos;
    logic input_sample_switch_neg;
    logic feedback_cap_switch_pos;
    logic feedback_cap_switch_neg;
    logic output_side_switch;
  } pao_switch_t;

  typedef enum logic [1:0] {TH_TRACK, TH_INPUT_OPEN, TH_FB_CLOSED, TH_HOLD} pao_th_state_t;
endpackage

// File: verif/pao_host.sv
/*
  Host model: makes the conversion clock and captures output words.
  Assumes the bench resolves the data bus from the enable it sees.
*/
`timescale 1ns/10ps
`default_nettype none
module pao_host #(
  parameter int HALF = 5
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic run,
  input wire logic shutdown_request,
  input wire logic [11:0] data_bus,
  output logic conv_clk_p,
  output logic conv_clk_n,
  output logic [15:0] rises,
  output logic [11:0] word,
  output logic fresh
);
  logic [7:0] ph;
  logic [3:0] since;
  //////////////////////////////////////////
  // Clock rate bounds
  // Clock stands low when idle, but a high phase always finishes cleanly.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ph <= 8'h00;
      conv_clk_p <= 1'b0;
      rises <= 16'h0000;
    end else if (run || conv_clk_p) begin
      ph <= (ph == 8'(HALF - 1)) ? 8'h00 : ph + 8'h01;
      if (ph == 8'(HALF - 1)) begin
        conv_clk_p <= ~conv_clk_p;
        rises <= rises + {15'h0000, ~conv_clk_p};
      end
    end
  end
  assign conv_clk_n = ~conv_clk_p;
  // Word bit order
  // Bus bit 0 is kept as the least significant bit, read mid high phase.
  always_ff @(posedge clk) begin
    if (conv_clk_p && ph == 8'h03) begin
      word <= data_bus;
    end
  end
  // Refill after shutdown
  // Words are trusted from the eighth rise on: the first sample after release
  // is taken at the first rise and its word lands seven rises later.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      since <= 4'h0;
    end else if (shutdown_request) begin
      since <= 4'h0;
    end else if (run && !conv_clk_p && ph == 8'(HALF - 1) && since != 4'h8) begin
      since <= since + 4'h1;
    end
  end
  assign fresh = (since == 4'h8);
endmodule
`default_nettype wire

// File: verif/testbench.sv
/*
  Self-checking bench for the converter's digital side.
  Assumes the host model makes the conversion clock and reads the words.
*/
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin err_count++; \
  $display("Error %s expected %h seen %h", n, e, g); end end
module testbench;
  import pao_pkg::*;
  logic clk, reset_n, run, shutdown_request, output_enable_n, fresh;
  logic conv_clk_p, conv_clk_n, sample_word_oe_n;
  logic se_mode, conv_n_pin;
  pao_comp_t [11:0] stage_comp;
  logic [11:0] sample_word_out, word;
  pao_switch_t th_switch;
  logic [15:0] rises;
  wire [11:0] data_bus;
  int err_count, compares, cycles;
  logic [35:0] rows [7];
  //////////////////////////////////////////
  // Released bus reads as high impedance.
  assign data_bus = sample_word_oe_n ? 12'hZZZ : sample_word_out;
  // Single-ended mode rests the complement pin high, so only the true clock's edges count.
  assign conv_n_pin = se_mode ? 1'b1 : conv_clk_n;
  pao_top i_pao_top (.clk(clk), .reset_n(reset_n), .conv_clk_p(conv_clk_p),
    .conv_clk_n(conv_n_pin), .stage_comp(stage_comp), .shutdown_request(shutdown_request),
    .output_enable_n(output_enable_n), .sample_word_out(sample_word_out),
    .sample_word_oe_n(sample_word_oe_n), .th_switch(th_switch));
  pao_host #(.HALF(5)) i_pao_host (.clk(clk), .reset_n(reset_n), .run(run),
    .shutdown_request(shutdown_request), .data_bus(data_bus), .conv_clk_p(conv_clk_p),
    .conv_clk_n(conv_clk_n), .rises(rises), .word(word), .fresh(fresh));
  // System clock at 100 MHz.
  always #5 clk = ~clk;
  // Cycle ceiling, far above the thousand or so cycles the run needs.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      conclude();
    end
  end
  task automatic conclude();
    $display("Compares %0d, errors %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Waits for n more rises, then until the host has read the word.
  task automatic wait_rises(input int n);
    int t;
    t = rises + n;
    while (rises < t) @(posedge clk);
    repeat (5) @(posedge clk);
  endtask
  //////////////////////////////////////////
  // Main sequence: table rows first, then latency, switches, shutdown, enable.
  initial begin
    clk = 1'b0;
    reset_n = 1'b0;
    run = 1'b0;
    se_mode = 1'b0;
    shutdown_request = 1'b0;
    output_enable_n = 1'b0;
    stage_comp = 24'h555555;
    rows = '{36'hFFFFFFFFF, 36'h000000000, 36'hAAAAAAFFF, 36'h555557C00,
      36'hD55555800, 36'h555554400, 36'h555555800};
    repeat (8) @(posedge clk);
    `CHK("bus in reset", 12'hZZZ, data_bus)
    reset_n <= 1'b1;
    @(posedge clk);
    run <= 1'b1;
    foreach (rows[i]) begin
      stage_comp <= rows[i][35:12];
      wait_rises(10);
      `CHK("word", rows[i][11:0], word)
    end
    // Switch all codes at a rise; the sample before it mixes old and new.
    @(posedge clk iff (i_pao_host.ph == 8'h04 && !conv_clk_p));
    stage_comp <= 24'hFFFFFF;
    wait_rises(7);
    `CHK("mixed word", 12'h9FF, sample_word_out)
    wait_rises(1);
    `CHK("latency word", 12'hFFF, sample_word_out)
    // Track-and-hold order after a rise.
    @(posedge clk iff (i_pao_host.ph == 8'h04 && !conv_clk_p));
    repeat (3) @(posedge clk);
    #1;
    `CHK("switch", 5'h06, th_switch)
    @(posedge clk);
    #1;
    `CHK("switch", 5'h07, th_switch)
    @(posedge clk);
    shutdown_request <= 1'b1;
    stage_comp <= 24'h000000;
    wait_rises(10);
    `CHK("held word", 12'hFFF, word)
    `CHK("input switch", 1'b0, th_switch.input_sample_switch_pos)
    shutdown_request <= 1'b0;
    // Switch to a single-ended clock in the low phase, where the complement is already high.
    se_mode <= 1'b1;
    @(posedge clk);
    while (!fresh) @(posedge clk);
    wait_rises(0);
    `CHK("refilled word", 12'h000, word)
    output_enable_n <= 1'b1;
    @(posedge clk);
    #1;
    `CHK("enable", 1'b1, sample_word_oe_n)
    `CHK("bus off", 12'hZZZ, data_bus)
    @(posedge clk);
    output_enable_n <= 1'b0;
    @(posedge clk);
    #1;
    `CHK("bus on", 12'h000, data_bus)
    conclude();
  end
endmodule
`default_nettype wire
